// ==== verilog/fwq_top.sv ====
// fwq_top: field weakening and quench sequencing for a dc drive
// assumes command pins are asynchronous and feedback is on mclk_in
//
// The register addresses and strobed register access were left to the implementer.
module fwq_top
    import fwq_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // drive commands
    input wire logic run_in,
    input wire logic start_in,
    input wire logic jog_in,
    input wire logic contactor_open_in,
    // feedback and reference
    input wire logic [13:0] arm_volts_in,
    input wire logic [13:0] field_ref_in,
    // register port
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // field demand
    output logic [13:0] field_demand_out,
    output logic quenched_out
);
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic running;
    logic run_cmd;
    logic weakening_enable;
    logic standby_field_on;
    logic [12:0] quench_delay_time;
    logic [13:0] standby_field_level;
    logic [13:0] minimum_field_level;
    logic [13:0] spillover_level;
    logic [13:0] rated_field;
    logic [15:0] weakening_p_gain;
    logic [15:0] weakening_i_time;
    logic [15:0] weakening_d_time;
    logic [15:0] feedback_d_time;
    logic [15:0] feedback_i_time;
    fwq_state_e state;
    logic [23:0] tick_cnt;
    logic [12:0] tenths;
    logic [13:0] ref_clamped;
    logic [13:0] standby_scaled;
    logic [13:0] next_demand;
    logic [27:0] sb_prod;
    logic [13:0] wk_floor;
    logic [17:0] tenth_floor;
    fwq_if lp();

    // two-flop sync of the run, start and jog command pins
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {run_in, start_in, jog_in};
            sync2 <= sync1;
        end
    end

    assign run_cmd = sync2[2];
    assign running = run_cmd && (sync2[1] || sync2[0]);

    // register writes, out-of-range values saturate, except the rated field, which keeps only the low 14 bits
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            weakening_enable <= 1'b0;
            standby_field_on <= 1'b0;
            quench_delay_time <= QUENCH_RST;
            standby_field_level <= STANDBY_RST;
            minimum_field_level <= MIN_FIELD_RST;
            spillover_level <= SPILL_RST;
            weakening_p_gain <= P_GAIN_RST;
            weakening_i_time <= I_TIME_RST;
            weakening_d_time <= D_TIME_RST;
            feedback_d_time <= FB_D_RST;
            feedback_i_time <= FB_I_RST;
            rated_field <= RATED_RST;
        end else if (wr_in) begin
            case (addr_in)
                A_CTRL: begin
                    weakening_enable <= wdata_in[0];
                    standby_field_on <= wdata_in[1];
                end
                A_QUENCH: quench_delay_time <= (wdata_in[12:0] > QUENCH_MAX ||
                    wdata_in[15:13] != 3'h0) ? QUENCH_MAX : wdata_in[12:0];
                A_STANDBY: standby_field_level <= (wdata_in > 16'(PCT_FULL)) ?
                    PCT_FULL : wdata_in[13:0];
                A_MIN: minimum_field_level <= (wdata_in > 16'(PCT_FULL)) ?
                    PCT_FULL : wdata_in[13:0];
                A_SPILL: spillover_level <= (wdata_in > 16'(PCT_FULL)) ?
                    PCT_FULL : wdata_in[13:0];
                A_PGAIN: weakening_p_gain <= wdata_in;
                A_ITIME: weakening_i_time <= (wdata_in > I_TIME_MAX) ?
                    I_TIME_MAX : wdata_in;
                A_DTIME: weakening_d_time <= wdata_in;
                A_FBD: feedback_d_time <= (wdata_in < FB_D_MIN) ? FB_D_MIN :
                    (wdata_in > FB_D_MAX) ? FB_D_MAX : wdata_in;
                A_FBI: feedback_i_time <= wdata_in;
                A_RATED: rated_field <= wdata_in[13:0];
                default: ;
            endcase
        end
    end

    // readback, one cycle after the strobe
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                A_CTRL: rdata_out <= {14'h0000, standby_field_on,
                    weakening_enable};
                A_QUENCH: rdata_out <= {3'h0, quench_delay_time};
                A_STANDBY: rdata_out <= {2'h0, standby_field_level};
                A_MIN: rdata_out <= {2'h0, minimum_field_level};
                A_SPILL: rdata_out <= {2'h0, spillover_level};
                A_PGAIN: rdata_out <= weakening_p_gain;
                A_ITIME: rdata_out <= weakening_i_time;
                A_DTIME: rdata_out <= weakening_d_time;
                A_FBD: rdata_out <= feedback_d_time;
                A_FBI: rdata_out <= feedback_i_time;
                A_STATUS: rdata_out <= {12'h000, running, 1'b0,
                    2'(state)};
                A_RATED: rdata_out <= {2'h0, rated_field};
                default: rdata_out <= 16'h0000;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

    // quench sequencing
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= FWQ_QUENCHED;
            tick_cnt <= '0;
            tenths <= '0;
        end else begin
            case (state)
                FWQ_RUN: begin
                    tick_cnt <= '0;
                    tenths <= '0;
                    if (!running) begin
                        state <= run_cmd ? FWQ_DELAY : FWQ_QUENCHED;
                    end
                end
                FWQ_DELAY: begin
                    if (running) begin
                        state <= FWQ_RUN;
                    end else if (!run_cmd) begin
                        state <= FWQ_QUENCHED;
                    end else if (!contactor_open_in) begin
                        tick_cnt <= '0;
                    end else if (tenths >= quench_delay_time) begin
                        state <= FWQ_QUENCHED;
                    end else if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
                        tick_cnt <= '0;
                        tenths <= tenths + 13'h0001;
                    end else begin
                        tick_cnt <= tick_cnt + 24'h000001;
                    end
                end
                FWQ_QUENCHED: begin
                    tick_cnt <= '0;
                    tenths <= '0;
                    if (running) begin
                        state <= FWQ_RUN;
                    end
                end
                default: state <= FWQ_QUENCHED;
            endcase
        end
    end

    always_comb begin
        ref_clamped = (field_ref_in < minimum_field_level) ?
            minimum_field_level : field_ref_in;
        tenth_floor = 18'(ref_clamped) / 18'd10;
        wk_floor = (14'(tenth_floor) > minimum_field_level) ?
            14'(tenth_floor) : minimum_field_level;
        sb_prod = 28'(standby_field_level) * 28'(rated_field);
        standby_scaled = 14'(sb_prod / 28'(PCT_FULL));
        case (state)
            FWQ_RUN, FWQ_DELAY: next_demand = lp.field_pct;
            FWQ_QUENCHED: next_demand = standby_field_on ? standby_scaled :
                14'h0000;
            default: next_demand = 14'h0000;
        endcase
    end

    // loop inputs
    assign lp.spill = spillover_level;
    assign lp.arm_volts = arm_volts_in;
    assign lp.floor_lvl = wk_floor;
    assign lp.ceil_lvl = ref_clamped;
    assign lp.p_gain = weakening_p_gain;
    assign lp.i_time = weakening_i_time;
    assign lp.enable = weakening_enable && state == FWQ_RUN;

    fwq_weaken u_weaken (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .lp(lp)
    );

    // registered demand
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            field_demand_out <= '0;
            quenched_out <= 1'b1;
        end else begin
            field_demand_out <= next_demand;
            quenched_out <= state == FWQ_QUENCHED;
        end
    end

    chk_run_decode: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        running == (sync2 inside {3'b101, 3'b110, 3'b111}))
        else $error("running decode wrong");
    chk_quench_zero: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (state == FWQ_QUENCHED && !standby_field_on) |=>
        field_demand_out == 14'h0000)
        else $error("field not zero when quenched");
    chk_run_drop: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (state == FWQ_DELAY && !run_cmd && !running) |=>
        state == FWQ_QUENCHED)
        else $error("run low did not quench");
    chk_rerun: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (state != FWQ_RUN && running) |=> state == FWQ_RUN)
        else $error("running not restored");
    chk_hold_field: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (state == FWQ_RUN && !running && run_cmd) |=>
        state == FWQ_DELAY)
        else $error("delay not started");
    // loop result above minimum, once the setting is settled
    chk_min_clamp: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        ($past(arst_n_in) && $stable(minimum_field_level)) |->
        lp.field_pct >= minimum_field_level)
        else $error("below minimum field");
    chk_standby_lvl: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        (state == FWQ_QUENCHED && standby_field_on) |=>
        field_demand_out == $past(standby_scaled))
        else $error("standby level wrong");
    chk_quench_rng: assert property (@(posedge mclk_in)
        disable iff (!arst_n_in)
        quench_delay_time <= QUENCH_MAX)
        else $error("quench delay out of range");
    cov_delay: cover property (@(posedge mclk_in) state == FWQ_DELAY);
    cov_timeout: cover property (@(posedge mclk_in)
        state == FWQ_DELAY ##1 state == FWQ_QUENCHED);
    cov_standby: cover property (@(posedge mclk_in)
        state == FWQ_QUENCHED && standby_field_on);
endmodule : fwq_top

// ==== verilog/fwq_pkg.sv ====
// fwq_pkg: constants for field weakening and quench control
// assumes a 10 MHz core clock and percent values in hundredths
package fwq_pkg;
    // clock rate and tick
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // quench delay in tenths of a second
    localparam logic [12:0] QUENCH_MAX = 13'h1770;
    localparam logic [12:0] QUENCH_RST = 13'h0064;
    // levels in hundredths of a percent
    localparam logic [13:0] PCT_FULL = 14'h2710;
    localparam logic [13:0] STANDBY_RST = 14'h09c4;
    localparam logic [13:0] MIN_FIELD_RST = 14'h03e8;
    localparam logic [13:0] SPILL_RST = 14'h2710;
    // weakening loop settings
    localparam logic [15:0] P_GAIN_RST = 16'h0032;
    localparam logic [15:0] I_TIME_RST = 16'h0fa0;
    localparam logic [15:0] I_TIME_MAX = 16'h4e20;
    localparam logic [15:0] D_TIME_RST = 16'h00c8;
    localparam logic [15:0] FB_D_RST = 16'h0064;
    localparam logic [15:0] FB_D_MIN = 16'h000a;
    localparam logic [15:0] FB_D_MAX = 16'h1388;
    localparam logic [15:0] FB_I_RST = 16'h0064;
    // register offsets
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_QUENCH = 4'h1;
    localparam logic [3:0] A_STANDBY = 4'h2;
    localparam logic [3:0] A_MIN = 4'h3;
    localparam logic [3:0] A_SPILL = 4'h4;
    localparam logic [3:0] A_PGAIN = 4'h5;
    localparam logic [3:0] A_ITIME = 4'h6;
    localparam logic [3:0] A_DTIME = 4'h7;
    localparam logic [3:0] A_FBD = 4'h8;
    localparam logic [3:0] A_FBI = 4'h9;
    localparam logic [3:0] A_STATUS = 4'ha;
    localparam logic [3:0] A_RATED = 4'hb;
    localparam logic [13:0] RATED_RST = 14'h3fff;
    typedef enum logic [1:0] {FWQ_RUN, FWQ_DELAY, FWQ_QUENCHED} fwq_state_e;
endpackage : fwq_pkg

// ==== verilog/fwq_if.sv ====
// fwq_if: loop setpoints and result between top and weakening loop
// assumes a single clock domain
interface fwq_if;
    logic [13:0] spill;
    logic [13:0] arm_volts;
    logic [13:0] floor_lvl;
    logic [13:0] ceil_lvl;
    logic [15:0] p_gain;
    logic [15:0] i_time;
    logic enable;
    logic [13:0] field_pct;
    modport top (output spill, arm_volts, floor_lvl, ceil_lvl, p_gain,
        i_time, enable, input field_pct);
    modport loop (input spill, arm_volts, floor_lvl, ceil_lvl, p_gain,
        i_time, enable, output field_pct);
endinterface : fwq_if

// ==== verilog/fwq_weaken.sv ====
// fwq_weaken: armature voltage spillover loop lowering field demand
// assumes percent inputs in hundredths, updated on every clock
module fwq_weaken
    import fwq_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    fwq_if.loop lp
);
    logic signed [15:0] err;
    logic signed [31:0] acc;
    logic signed [31:0] next_acc;
    logic signed [31:0] step;
    logic signed [31:0] outv;
    logic [15:0] i_div;
    logic signed [31:0] gain_s;
    logic signed [31:0] ceil_s;
    logic signed [31:0] floor_s;
    logic signed [31:0] acc_max;

    // positive error means armature above spillover: weaken more
    // every operand kept signed, a negative error must not go unsigned
    always_comb begin
        err = $signed({2'b00, lp.arm_volts}) - $signed({2'b00, lp.spill});
        i_div = (lp.i_time == 16'h0000) ? 16'h0001 : lp.i_time;
        gain_s = $signed({16'h0000, lp.p_gain});
        ceil_s = $signed({18'h00000, lp.ceil_lvl});
        floor_s = $signed({18'h00000, lp.floor_lvl});
        acc_max = $signed({18'h00000, PCT_FULL}) * 32'sd64;
        step = (32'(err) * gain_s) / $signed({16'h0000, i_div});
        next_acc = acc + step;
        if (next_acc < 32'sd0) begin
            next_acc = 32'sd0;
        end
        if (next_acc > acc_max) begin
            next_acc = acc_max;
        end
        outv = ceil_s - (acc >>> 6) - (32'(err) * gain_s) / 32'sd64;
        if (outv < floor_s) begin
            outv = floor_s;
        end
        if (outv > ceil_s) begin
            outv = ceil_s;
        end
    end

    // integrator, held at zero while weakening is off
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc <= '0;
        end else if (!lp.enable) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lp.field_pct <= '0;
        end else if (!lp.enable) begin
            lp.field_pct <= lp.ceil_lvl;
        end else begin
            lp.field_pct <= outv[13:0];
        end
    end
endmodule : fwq_weaken

// ==== tb/fwq_contactor_model.sv ====
// fwq_contactor_model: main contactor sequence beside the field block
// assumes the bench clock and an async active-low reset
module fwq_contactor_model (
    // clock and reset
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // commands seen by the sequencer
    input wire logic run_in,
    input wire logic start_in,
    input wire logic jog_in,
    input wire logic [7:0] drop_cyc_in,
    // contactor state
    output logic contactor_open_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt;
    // drop out after a prompt or slow delay, close at once on a run
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= 8'h00;
            contactor_open_out <= 1'b1;
        end else if (run_in && (start_in || jog_in)) begin
            cnt <= 8'h00;
            contactor_open_out <= 1'b0;
        end else if (cnt >= drop_cyc_in || !run_in) begin
            contactor_open_out <= 1'b1; // run low never waits
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : fwq_contactor_model

// ==== tb/field_weakening_and_quench_control_tb.sv ====
// field_weakening_and_quench_control_tb: self-checking bench for fwq_top
// assumes fwq_pkg constants; long quench counts are only seen started
module field_weakening_and_quench_control_tb
    import fwq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_in, arst_n_in, run_in, start_in, jog_in, contactor_open;
    logic [13:0] arm_volts_in, field_ref_in, field_demand_out;
    logic [3:0] addr_in;
    logic [15:0] wdata_in, rdata_out;
    logic wr_in, rd_in, quenched_out;
    logic [7:0] drop_cyc;
    int err_total = 0;
    int samples_checked = 0;
    int unsigned seed = 32'h74c3;
    logic [15:0] dflt [13] = '{16'h0000, 16'h0064, 16'h09c4, 16'h03e8,
        16'h2710, 16'h0032, 16'h0fa0, 16'h00c8, 16'h0064, 16'h0064,
        16'h0002, 16'h3fff, 16'h0000};

    fwq_top dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .run_in(run_in),
        .start_in(start_in), .jog_in(jog_in),
        .contactor_open_in(contactor_open), .arm_volts_in(arm_volts_in),
        .field_ref_in(field_ref_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .field_demand_out(field_demand_out), .quenched_out(quenched_out));
    fwq_contactor_model partner (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .run_in(run_in), .start_in(start_in), .jog_in(jog_in),
        .drop_cyc_in(drop_cyc), .contactor_open_out(contactor_open));

    // free-running 10 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    function automatic int unsigned lfsr(input int unsigned x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // running demand: reference, never below the minimum level
    function automatic logic [13:0] exp_run(input int r, input int mn);
        return 14'(r < mn ? mn : r);
    endfunction : exp_run

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_word(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_dem(input string nm, input logic [13:0] e);
        chk_word(nm, {2'b00, e}, {2'b00, field_demand_out});
    endtask : chk_dem

    task automatic chk_flag(input string nm, input logic e);
        chk_word(nm, {15'h0000, e}, {15'h0000, quenched_out});
    endtask : chk_flag

    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : settle

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
    endtask : rd

    task automatic wait_dem(input logic [13:0] e);
        int k;
        k = 0;
        // the integrator needs several thousand cycles to reach the floor
        while (field_demand_out !== e && k < 20000) begin
            settle(1);
            k++;
        end
        if (field_demand_out !== e) begin
            err_total++;
            $display("wrong value wait demand expected %h seen %h", e,
                field_demand_out);
        end
    endtask : wait_dem

    initial begin
        logic [15:0] v;
        logic [13:0] r;
        int i;
        {run_in, start_in, jog_in, wr_in, rd_in} = 5'h00;
        {addr_in, wdata_in} = 20'h00000;
        arm_volts_in = 14'h2328;
        field_ref_in = 14'h2710;
        drop_cyc = 8'h04;
        arst_n_in = 1'b0;
        settle(3);
        chk_flag("reset quenched", 1'b1);
        arst_n_in <= 1'b1;
        // defaults of every setting, plus one unmapped offset
        for (i = 0; i < 13; i++) begin
            rd(4'(i), v);
            chk_word("default", dflt[i], v);
        end
        // out-of-range writes saturate at the documented limits
        wr(A_QUENCH, 16'hffff);
        rd(A_QUENCH, v);
        chk_word("quench max", 16'h1770, v);
        wr(A_ITIME, 16'hffff);
        rd(A_ITIME, v);
        chk_word("itime max", 16'h4e20, v);
        wr(A_FBD, 16'h0001);
        rd(A_FBD, v);
        chk_word("fbd min", 16'h000a, v);
        wr(A_STANDBY, 16'hffff);
        rd(A_STANDBY, v);
        chk_word("standby max", 16'h2710, v);
        wr(A_STANDBY, 16'h09c4);
        wr(A_ITIME, 16'h0fa0);
        wr(A_QUENCH, 16'h0000);
        // operator limits kept by the stimulus
        wr(A_MIN, 16'h03e8);
        wr(A_DTIME, 16'h0190);
        wr(A_FBD, 16'h00c8);
        rd(A_FBD, v);
        chk_word("fbd", 16'h00c8, v);
        rd(A_DTIME, v);
        chk_word("dtime", 16'h0190, v);
        // every command combination, zero quench delay
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            r = (i == 7) ? 14'h012c : 14'(seed % 10001);
            {run_in, start_in, jog_in} <= 3'(i);
            field_ref_in <= r;
            settle(20);
            rd(A_STATUS, v);
            chk_word("status", (i > 4) ? 16'h0008 : 16'h0002, v);
            chk_dem("dem", (i > 4) ? exp_run(r, 1000) : 14'h0000);
        end
        // stop with a long delay: field held, then a restart
        drop_cyc <= 8'h00;
        wr(A_QUENCH, 16'h0064);
        {start_in, jog_in} <= 2'b00;
        settle(60);
        rd(A_STATUS, v);
        chk_word("status delay", 16'h0001, v);
        chk_dem("held", 14'h03e8);
        start_in <= 1'b1;
        settle(10);
        rd(A_STATUS, v);
        chk_word("status rerun", 16'h0008, v);
        start_in <= 1'b0;
        settle(20);
        run_in <= 1'b0;
        settle(8);
        chk_flag("run low quench", 1'b1);
        chk_dem("quenched", 14'h0000);
        // standby level scaled by the rated field
        wr(A_CTRL, 16'h0002);
        settle(4);
        // full scale of the level setting maps onto the rated field
        chk_dem("standby", 14'(2500 * 16383 / 10000));
        wr(A_RATED, 16'h2000);
        settle(4);
        chk_dem("standby rated", 14'(2500 * 8192 / 10000));
        wr(A_RATED, 16'h3fff);
        wr(A_CTRL, 16'h0000);
        // weakening: high volts ignored until enabled, then floor
        wr(A_SPILL, 16'h1388);
        {run_in, start_in} <= 2'b11;
        field_ref_in <= 14'h2710;
        settle(20);
        chk_dem("no weakening", 14'h2710);
        wr(A_CTRL, 16'h0001);
        wait_dem(14'h03e8);
        chk_dem("floor", 14'h03e8);
        wr(A_CTRL, 16'h0000);
        wait_dem(14'h2710);
        chk_dem("restored", 14'h2710);
        print_verdict();
    end
endmodule : field_weakening_and_quench_control_tb
